// ===== bpw_pkg.sv
// Package for the bidirectional port block: register map, widths, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package bpw_pkg;
  localparam int BPW_NPORT = 5;
  localparam int BPW_W = 8;
  localparam int BPW_AW = 8;
  // Port index: 0=A 1=B 2=C 3=D 4=F; data at base+8*i, direction at base+8*i+4
  localparam logic [7:0] BPW_DATA_BASE = 8'h00;
  localparam logic [7:0] BPW_DIR_BASE = 8'h04;
  localparam logic [7:0] BPW_PORT_STRIDE = 8'h08;
  localparam logic [7:0] BPW_WAKE_EN_ADDR = 8'h28;
  localparam logic [7:0] BPW_PWR_CTRL_ADDR = 8'h2c;
  localparam logic [7:0] BPW_IRQ0_CTRL_ADDR = 8'h30;
  localparam logic [7:0] BPW_PORT_RESET = 8'hff;
  localparam logic [7:0] BPW_WAKE_RESET = 8'h00;
  localparam int BPW_HALT_BIT = 0;
  localparam int BPW_IRQ0_EN_BIT = 0;
  localparam int BPW_IRQ0_PIN = 5;
  localparam logic [31:0] BPW_ZERO32 = 32'h0000_0000;
endpackage

// ===== bpw_pin.sv
// One port pin: direction, push-pull or open-drain drive, pull-high request, read mux.
// Assumes the pin level is synchronous to the clock of the owning block.
`timescale 1ns/10ps
module bpw_pin (
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic pin_in,
  input wire logic nmos_opt,
  input wire logic pull_opt,
  output logic out_bit,
  output logic oe_bit,
  output logic pull_bit,
  output logic rd_bit
);
  always_comb begin
    // Direction bit 1 is input, 0 drives
    if (dir_bit) begin
      oe_bit = 1'b0;
      out_bit = latch_bit;
    end else if (nmos_opt) begin
      oe_bit = ~latch_bit;
      out_bit = 1'b0;
    end else begin
      oe_bit = 1'b1;
      out_bit = latch_bit;
    end
  end
  // Pull-high only on inputs with the option chosen
  assign pull_bit = dir_bit & pull_opt;
  // Output reads back the latch, never the pad
  assign rd_bit = dir_bit ? pin_in : latch_bit;
endmodule

// ===== bpw_port.sv
// Top of the bidirectional port block: five 8-bit ports, APB registers, wake-up.
// Assumes pins are synchronous to mclk; APB master is the CPU side.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
module bpw_port
  import bpw_pkg::*;
#(
  parameter int NPORT = BPW_NPORT,
  parameter logic [NPORT*BPW_W-1:0] NMOS_OPT = '0,
  parameter logic [NPORT*BPW_W-1:0] PULL_OPT = '0,
  parameter logic [NPORT*BPW_W-1:0] PIN_PRESENT = {8'h07, {(NPORT-1)*BPW_W{1'b1}}}
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [BPW_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPORT*BPW_W-1:0] pin_in,
  output logic [NPORT*BPW_W-1:0] pin_out,
  output logic [NPORT*BPW_W-1:0] pin_oe,
  output logic [NPORT*BPW_W-1:0] pin_pull,
  output logic irq0_enable,
  output logic power_down,
  output logic wake_event
);
  typedef enum logic [1:0] {
    BPW_RUN = 2'b01,
    BPW_HALT = 2'b10
  } bpw_pwr_t;

  logic [BPW_W-1:0] data_reg [NPORT];
  logic [BPW_W-1:0] dir_reg [NPORT];
  logic [BPW_W-1:0] wake_en_reg;
  logic irq0_en_reg;
  bpw_pwr_t pwr_reg;
  logic [BPW_W-1:0] porta_prev_reg;
  logic [NPORT*BPW_W-1:0] drv_out;
  logic [NPORT*BPW_W-1:0] drv_oe;
  logic [NPORT*BPW_W-1:0] drv_pull;
  logic [NPORT*BPW_W-1:0] rd_all;
  logic access;
  logic wr;
  logic [31:0] rd_data_next;
  logic hit;
  logic wake_hit;

  assign access = psel & penable;
  assign wr = access & pwrite;

  // Per-pin structure; absent pins stay undriven and read zero
  genvar gi;
  generate
    for (gi = 0; gi < NPORT*BPW_W; gi++) begin : g_pin
      logic raw_rd;
      bpw_pin u_pin (
        .latch_bit(data_reg[gi/BPW_W][gi%BPW_W]),
        .dir_bit(dir_reg[gi/BPW_W][gi%BPW_W]),
        .pin_in(pin_in[gi]),
        .nmos_opt(NMOS_OPT[gi]),
        .pull_opt(PULL_OPT[gi]),
        .out_bit(drv_out[gi]),
        .oe_bit(drv_oe[gi]),
        .pull_bit(drv_pull[gi]),
        .rd_bit(raw_rd)
      );
      assign rd_all[gi] = raw_rd & PIN_PRESENT[gi];
    end
  endgenerate

  // Data latches and direction registers; whole-byte writes carry bit ops
  always_ff @(posedge mclk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (rst) begin
        data_reg[p] <= BPW_PORT_RESET;
        dir_reg[p] <= BPW_PORT_RESET;
      end else if (wr) begin
        if (paddr == BPW_DATA_BASE + BPW_PORT_STRIDE * 8'(p)) begin
          data_reg[p] <= pwdata[BPW_W-1:0];
        end
        if (paddr == BPW_DIR_BASE + BPW_PORT_STRIDE * 8'(p)) begin
          dir_reg[p] <= pwdata[BPW_W-1:0];
        end
      end
    end
  end

  // Software-controlled alternate function select for the irq0 pin, and the Port A wake-up enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq0_en_reg <= 1'b0;
      wake_en_reg <= BPW_WAKE_RESET;
    end else if (wr) begin
      if (paddr == BPW_IRQ0_CTRL_ADDR) begin
        irq0_en_reg <= pwdata[BPW_IRQ0_EN_BIT];
      end
      if (paddr == BPW_WAKE_EN_ADDR) begin
        wake_en_reg <= pwdata[BPW_W-1:0];
      end
    end
  end

  // Falling edge on an enabled Port A pin; unselected pins are masked out
  assign wake_hit = |(porta_prev_reg & ~pin_in[BPW_W-1:0] & wake_en_reg);

  // Power state: halt write enters power-down, wake returns to run
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_reg <= BPW_RUN;
      porta_prev_reg <= BPW_PORT_RESET;
      wake_event <= 1'b0;
    end else begin
      porta_prev_reg <= pin_in[BPW_W-1:0];
      wake_event <= 1'b0;
      unique case (pwr_reg)
        BPW_RUN: begin
          if (wr && paddr == BPW_PWR_CTRL_ADDR && pwdata[BPW_HALT_BIT]) begin
            pwr_reg <= BPW_HALT;
          end
        end
        BPW_HALT: begin
          if (wake_hit) begin
            pwr_reg <= BPW_RUN;
            wake_event <= 1'b1;
          end
        end
        default: pwr_reg <= BPW_RUN;
      endcase
    end
  end

  // Read mux: pin level sampled at the access edge, no input latch kept
  always_comb begin
    rd_data_next = BPW_ZERO32;
    hit = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (paddr == BPW_DATA_BASE + BPW_PORT_STRIDE * 8'(p)) begin
        rd_data_next[BPW_W-1:0] = rd_all[p*BPW_W +: BPW_W];
        hit = 1'b1;
      end
      if (paddr == BPW_DIR_BASE + BPW_PORT_STRIDE * 8'(p)) begin
        rd_data_next[BPW_W-1:0] = dir_reg[p];
        hit = 1'b1;
      end
    end
    if (paddr == BPW_WAKE_EN_ADDR) begin
      rd_data_next[BPW_W-1:0] = wake_en_reg;
      hit = 1'b1;
    end
    if (paddr == BPW_PWR_CTRL_ADDR) begin
      rd_data_next[BPW_HALT_BIT] = (pwr_reg == BPW_HALT);
      hit = 1'b1;
    end
    if (paddr == BPW_IRQ0_CTRL_ADDR) begin
      rd_data_next[BPW_IRQ0_EN_BIT] = irq0_en_reg;
      hit = 1'b1;
    end
  end

  // One wait state: setup, access, then registered answer
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= BPW_ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit;
      if (access && !pready && !pwrite) begin
        prdata <= rd_data_next;
      end
    end
  end

  // Pins registered so every output leaves a flip-flop; irq0 pin released when its enable is set
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out <= {NPORT*BPW_W{1'b1}};
      pin_oe <= '0;
      pin_pull <= '0;
      irq0_enable <= 1'b0;
      power_down <= 1'b0;
    end else begin
      pin_out <= drv_out;
      pin_oe <= drv_oe & PIN_PRESENT;
      pin_pull <= drv_pull & PIN_PRESENT;
      if (irq0_en_reg) begin
        pin_oe[BPW_IRQ0_PIN] <= 1'b0;
      end
      irq0_enable <= irq0_en_reg;
      power_down <= (pwr_reg == BPW_HALT) & ~wake_hit;
    end
  end
endmodule

// ===== bpw_ext_model.sv
// Pad model: a switch on every pin, overridden where the block drives.
// Assumes the switches never fight a driving pin.
`timescale 1ns/10ps
module bpw_ext_model (
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe,
  input wire logic [39:0] sw,
  output logic [39:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw);
endmodule

// ===== bpw_port_chk.sv
// Checker for the port block.
// Assumes pins follow a bus write two edges after it is taken.
`timescale 1ns/10ps
module bpw_port_chk
  import bpw_pkg::*;
#(
  parameter int NPORT = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [NPORT*8-1:0] pin_in,
  input wire logic [NPORT*8-1:0] pin_out,
  input wire logic [NPORT*8-1:0] pin_oe,
  input wire logic [NPORT*8-1:0] pin_pull,
  input wire logic irq0_enable,
  input wire logic power_down,
  input wire logic wake_event
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire tk = psel & penable & !pready & pwrite;
  sequence halt_req;
    tk && paddr == BPW_PWR_CTRL_ADDR && pwdata[0];
  endsequence
  // Pin changes without a bus write point at a stuck or stray register
  reset_idle_a: assert property ($fell(rst) |-> pin_oe == '0 && !power_down) else $error("reset");
  oe_cause_a: assert property ($changed(pin_oe) |-> $past(tk, 2)) else $error("oe moved");
  out_cause_a: assert property ($changed(pin_out) |-> $past(tk, 2)) else $error("out moved");
  halt_enter_a: assert property (halt_req |-> ##[1:2] power_down) else $error("no halt");
  wake_exit_a: assert property (wake_event |-> $past(power_down) && !power_down) else $error("wake");
  wake_hold_a: assert property ((power_down && $stable(pin_in[7:0]) && !psel) [*3] |=> power_down)
    else $error("woke alone");
  pull_in_a: assert property ((pin_pull & pin_oe) == '0) else $error("pull on output");
  irq_pin_a: assert property ($past(irq0_enable) && irq0_enable |-> !pin_oe[5]) else $error("irq pin");
endmodule
bind bpw_port bpw_port_chk #(.NPORT(NPORT)) chk_u (.*);

// ===== testbench.sv
// Self-checking bench for the port block, one task per scenario.
// Assumes the pad model turns the switches in sw into pin_in.
`timescale 1ns/10ps
module testbench;
  import bpw_pkg::*;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, w;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, irq0_enable, power_down, wake_event;
  logic [39:0] pin_in, pin_out, pin_oe, pin_pull, sw = '1;
  int failures = 0, total_checks = 0;
  always #12.5 mclk = ~mclk;
  bpw_port dut_u (.*);
  bpw_ext_model ext_u (.*);
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task give_verdict;
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      bus(0, 8'(8 * i + 4), 0);
      chk(q, 32'hff);
    end
    chk(pin_oe, 40'h0);
    chk(pin_pull, 40'h0);
  endtask
  task t_io;
    bus(1, 8'h0c, 32'hf0);
    bus(1, 8'h08, 32'h5a);
    sw[15:8] <= 8'h33;
    bus(0, 8'h08, 0);
    chk(q, 32'h3a);
    chk(pin_oe[15:8], 8'h0f);
    chk(pin_out[11:8], 4'ha);
    bus(0, 8'h0c, 0);
    bus(1, 8'h0c, q & 32'h7f);
    sw[15:8] <= 8'hc5;
    bus(0, 8'h08, 0);
    chk(q, 32'h4a);
    chk(pin_oe[15:8], 8'h8f);
    chk(pin_out[15], 1'b0);
  endtask
  task t_wake;
    w = 0;
    bus(1, BPW_WAKE_EN_ADDR, 32'h04);
    bus(1, BPW_PWR_CTRL_ADDR, 32'h01);
    // power_down leaves its flop on the same edge at which pready is seen
    @(posedge mclk);
    chk(power_down, 1'b1);
    sw[3] <= 0;
    repeat (4) @(posedge mclk);
    chk(power_down, 1'b1);
    sw[2] <= 0;
    repeat (4) begin
      @(posedge mclk);
      w = w | wake_event;
    end
    chk(w, 1'b1);
    chk(power_down, 1'b0);
  endtask
  task t_refuse;
    bus(0, 8'h3c, 0);
    chk({err, q}, 33'h1_0000_0000);
    bus(1, BPW_IRQ0_CTRL_ADDR, 32'h01);
    bus(1, BPW_DIR_BASE, 0);
    bus(0, BPW_DATA_BASE, 0);
    chk(pin_oe[7:0], 8'hdf);
    chk(irq0_enable, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    t_reset;
    t_io;
    t_wake;
    t_refuse;
    give_verdict;
  end
  // About twenty times the expected run
  initial begin
    #50us;
    failures++;
    give_verdict;
  end
endmodule
